// ==== include/pulse_ref_cfg.svh ====
// constants of the pulse train reference decoder
`ifndef PULSE_REF_CFG_SVH
`define PULSE_REF_CFG_SVH

`define CLK_MHZ 100

// register byte offsets
`define OFS_MODE 12'h000
`define OFS_FORM 12'h004
`define OFS_FILT 12'h008
`define OFS_POS 12'h00C
`define OFS_STAT 12'h010

// field positions, each field a nibble
`define MODE_FIELD_LSB 4
`define FORM_FIELD_LSB 8
`define INV_FIELD_LSB 12
`define FILT_FIELD_LSB 12

// reset values and codes
`define MODE_RST 32'h0000_0000
`define FORM_RST 32'h0000_0000
`define FILT_RST 32'h0000_0000
`define MODE_POSITION 4'h1

// least pulse half period per filter setting, ns
`define FILT0_NS 125
`define FILT1_NS 769
`define FILT2_NS 3333
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ) / 1000)
`define FILT0_CYC `NS_TO_CYC(`FILT0_NS)
`define FILT1_CYC `NS_TO_CYC(`FILT1_NS)
`define FILT2_CYC `NS_TO_CYC(`FILT2_NS)

`endif

// ==== include/pulse_ref_pkg.sv ====
// types of the pulse train reference decoder
package pulse_ref_pkg;
	typedef enum logic [3:0]
	{
		FORM_SIGN_PULSE = 4'h0,
		FORM_FWD_REV = 4'h1,
		FORM_QUAD_X1 = 4'h2,
		FORM_QUAD_X2 = 4'h3,
		FORM_QUAD_X4 = 4'h4
	} pulse_form_t;

	typedef enum logic [2:0]
	{
		APB_IDLE = 3'b001,
		APB_WAIT = 3'b010,
		APB_DONE = 3'b100
	} apb_state_t;
endpackage

// ==== include/pulse_link_if.sv ====
// carrier between the top and the pulse decoder
`timescale 1ns/1ns
interface pulse_link_if;
	import pulse_ref_pkg::*;
	logic run;
	logic line_a;
	logic line_b;
	logic [3:0] form;
	logic step;
	logic step_fwd;

	modport src
	(
		output run,
		output line_a,
		output line_b,
		output form,
		input step,
		input step_fwd
	);

	modport dec
	(
		input run,
		input line_a,
		input line_b,
		input form,
		output step,
		output step_fwd
	);
endinterface

// ==== core/glitch_filter.sv ====
// one-line glitch filter with selectable settle time
`timescale 1ns/1ns
module glitch_filter
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// line
	input wire logic raw,
	input wire logic [15:0] settle,
	output logic filt
);
	logic filt_r;
	logic filt_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;

	always_comb
	begin
		filt_nxt = filt_r;
		cnt_nxt = 16'h0000;
		if (raw != filt_r)
		begin
			// a level shorter than settle never reaches the output
			if (cnt_r + 16'h0001 >= settle)
				filt_nxt = raw;
			else
				cnt_nxt = cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			filt_r <= 1'b0;
			cnt_r <= 16'h0000;
		end
		else
		begin
			filt_r <= filt_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign filt = filt_r;
endmodule // glitch_filter

// ==== core/pulse_decoder.sv ====
// turns two filtered lines into direction-qualified steps
`timescale 1ns/1ns
module pulse_decoder
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link to top
	pulse_link_if.dec lnk
);
	import pulse_ref_pkg::*;

	logic a_r;
	logic b_r;
	logic step_r;
	logic fwd_r;
	logic step_nxt;
	logic fwd_nxt;
	logic a_rise;
	logic b_rise;
	logic a_edge;
	logic b_edge;

	always_comb
	begin
		a_rise = lnk.line_a & ~a_r;
		b_rise = lnk.line_b & ~b_r;
		a_edge = lnk.line_a ^ a_r;
		b_edge = lnk.line_b ^ b_r;
		step_nxt = 1'b0;
		fwd_nxt = fwd_r;
		if (lnk.run)
		begin
			unique case (lnk.form)
				FORM_SIGN_PULSE:
				begin
					step_nxt = a_rise;
					fwd_nxt = a_rise ? lnk.line_b : fwd_r;
				end
				FORM_FWD_REV:
				begin
					// both lines at once is a host fault; no step is made, but the direction is set forward
					step_nxt = a_rise ^ b_rise;
					fwd_nxt = a_rise ? 1'b1 : (b_rise ? 1'b0 : fwd_r);
				end
				FORM_QUAD_X1:
				begin
					step_nxt = a_rise;
					fwd_nxt = a_rise ? lnk.line_b : fwd_r;
				end
				FORM_QUAD_X2:
				begin
					step_nxt = a_edge;
					fwd_nxt = a_edge ? (lnk.line_a == lnk.line_b) : fwd_r;
				end
				FORM_QUAD_X4:
				begin
					// both phases moving together is an illegal jump, dropped
					step_nxt = a_edge ^ b_edge;
					if (a_edge & ~b_edge)
						fwd_nxt = (lnk.line_a == lnk.line_b);
					else if (b_edge & ~a_edge)
						fwd_nxt = (lnk.line_a != lnk.line_b);
				end
				default:
				begin
					step_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			a_r <= 1'b0;
			b_r <= 1'b0;
			step_r <= 1'b0;
			fwd_r <= 1'b1;
		end
		else
		begin
			a_r <= lnk.line_a;
			b_r <= lnk.line_b;
			step_r <= step_nxt;
			fwd_r <= fwd_nxt;
		end
	end

	assign lnk.step = step_r;
	assign lnk.step_fwd = fwd_r;
endmodule // pulse_decoder

// ==== core/pulse_train_reference_decoder.sv ====
// pulse train position reference decoder with apb registers
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "pulse_ref_cfg.svh"
module pulse_train_reference_decoder
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reference lines from the host
	input wire logic pulse_in,
	input wire logic dir_in,
	// to the position loop
	output logic ref_step,
	output logic ref_fwd,
	output pulse_ref_pkg::pulse_form_t active_form
);
	import pulse_ref_pkg::*;

	// register file
	logic [31:0] control_mode_select_param_r;
	logic [31:0] control_mode_select_param_nxt;
	logic [31:0] position_input_form_param_r;
	logic [31:0] position_input_form_param_nxt;
	logic [31:0] input_filter_param_r;
	logic [31:0] input_filter_param_nxt;
	logic [31:0] pos_count_r;
	logic [31:0] pos_count_nxt;

	// apb handshake
	apb_state_t apb_state_r;
	apb_state_t apb_state_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic pready_r;
	logic pready_nxt;
	logic wr_fire;
	logic [31:0] rd_word;
	logic rd_hit;

	// line path
	logic [3:0] pulse_form_field;
	logic [3:0] inv_field;
	logic [3:0] open_collector_filter_field;
	logic position_mode;
	logic pulse_inv;
	logic dir_inv;
	logic [15:0] settle;
	logic pulse_filt;
	logic dir_filt;
	logic ref_step_r;
	logic ref_fwd_r;
	pulse_form_t active_form_r;
	pulse_form_t active_form_nxt;

	pulse_link_if lnk ();

	function automatic logic [3:0] nibble(input logic [31:0] word, input int lsb);
		nibble = word[lsb +: 4];
	endfunction

	function automatic logic [15:0] settle_of(input logic [3:0] sel);
		unique case (sel)
			4'h1: settle_of = 16'(`FILT1_CYC);
			4'h2: settle_of = 16'(`FILT2_CYC);
			default: settle_of = 16'(`FILT0_CYC);
		endcase
	endfunction

	// field decode
	always_comb
	begin
		pulse_form_field = nibble(position_input_form_param_r, `FORM_FIELD_LSB);
		inv_field = nibble(position_input_form_param_r, `INV_FIELD_LSB);
		open_collector_filter_field = nibble(input_filter_param_r, `FILT_FIELD_LSB);
		position_mode = (nibble(control_mode_select_param_r, `MODE_FIELD_LSB) == `MODE_POSITION);
		dir_inv = (inv_field == 4'h1) | (inv_field == 4'h3);
		pulse_inv = (inv_field == 4'h2) | (inv_field == 4'h3);
		settle = settle_of(open_collector_filter_field);
	end

	// a fast host edge is rejected as noise, see the filter setting
	glitch_filter u_filt_pulse
	(
		.clk(clk),
		.nrst(nrst),
		.raw(pulse_in ^ pulse_inv),
		.settle(settle),
		.filt(pulse_filt)
	);

	glitch_filter u_filt_dir
	(
		.clk(clk),
		.nrst(nrst),
		.raw(dir_in ^ dir_inv),
		.settle(settle),
		.filt(dir_filt)
	);

	assign lnk.run = position_mode;
	assign lnk.line_a = pulse_filt;
	assign lnk.line_b = dir_filt;
	assign lnk.form = pulse_form_field;

	pulse_decoder u_dec
	(
		.clk(clk),
		.nrst(nrst),
		.lnk(lnk)
	);

	// read mux; status bits are live, not latched
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (paddr)
			`OFS_MODE: rd_word = control_mode_select_param_r;
			`OFS_FORM: rd_word = position_input_form_param_r;
			`OFS_FILT: rd_word = input_filter_param_r;
			`OFS_POS: rd_word = pos_count_r;
			`OFS_STAT: rd_word = {26'h0000000, position_mode, ref_fwd_r, dir_filt, pulse_filt, 2'h0};
			default:
			begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// apb: one wait state, answer registered
	always_comb
	begin
		apb_state_nxt = apb_state_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		pready_nxt = 1'b0;
		wr_fire = 1'b0;
		unique case (apb_state_r)
			APB_IDLE:
			begin
				if (psel & penable)
				begin
					apb_state_nxt = APB_WAIT;
					prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
					pslverr_nxt = ~rd_hit;
					pready_nxt = 1'b1;
				end
			end
			APB_WAIT:
			begin
				// pready is high now; the write lands on this edge
				wr_fire = pwrite & rd_hit;
				apb_state_nxt = APB_DONE;
			end
			APB_DONE:
			begin
				apb_state_nxt = APB_IDLE;
			end
			default:
			begin
				apb_state_nxt = APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			apb_state_r <= APB_IDLE;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
		end
		else
		begin
			apb_state_r <= apb_state_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			pready_r <= pready_nxt;
		end
	end

	// register writes and position count
	always_comb
	begin
		control_mode_select_param_nxt = control_mode_select_param_r;
		position_input_form_param_nxt = position_input_form_param_r;
		input_filter_param_nxt = input_filter_param_r;
		pos_count_nxt = pos_count_r;
		if (lnk.step)
			pos_count_nxt = lnk.step_fwd ? pos_count_r + 32'h0000_0001 : pos_count_r - 32'h0000_0001;
		if (wr_fire)
		begin
			unique case (paddr)
				`OFS_MODE: control_mode_select_param_nxt = pwdata;
				`OFS_FORM: position_input_form_param_nxt = pwdata;
				`OFS_FILT: input_filter_param_nxt = pwdata;
				// software load of the count wins over a step in the same cycle
				`OFS_POS: pos_count_nxt = pwdata;
				default:
				begin
					pos_count_nxt = pos_count_nxt;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			control_mode_select_param_r <= `MODE_RST;
			position_input_form_param_r <= `FORM_RST;
			input_filter_param_r <= `FILT_RST;
			pos_count_r <= 32'h0000_0000;
		end
		else
		begin
			control_mode_select_param_r <= control_mode_select_param_nxt;
			position_input_form_param_r <= position_input_form_param_nxt;
			input_filter_param_r <= input_filter_param_nxt;
			pos_count_r <= pos_count_nxt;
		end
	end

	// output stage; an illegal form code shows as sign+pulse but counts nothing
	always_comb
	begin
		unique case (pulse_form_field)
			4'h1: active_form_nxt = FORM_FWD_REV;
			4'h2: active_form_nxt = FORM_QUAD_X1;
			4'h3: active_form_nxt = FORM_QUAD_X2;
			4'h4: active_form_nxt = FORM_QUAD_X4;
			default: active_form_nxt = FORM_SIGN_PULSE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ref_step_r <= 1'b0;
			ref_fwd_r <= 1'b1;
			active_form_r <= FORM_SIGN_PULSE;
		end
		else
		begin
			ref_step_r <= lnk.step;
			ref_fwd_r <= lnk.step_fwd;
			active_form_r <= active_form_nxt;
		end
	end

	assign prdata = prdata_r;
	// own flop, high exactly while the state sits in wait; no decode on the pin
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign ref_step = ref_step_r;
	assign ref_fwd = ref_fwd_r;
	assign active_form = active_form_r;
endmodule // pulse_train_reference_decoder

// ==== sim/decoder_asserts.sv ====
// port assertions for the pulse train reference decoder
`timescale 1ns/1ns
`include "pulse_ref_cfg.svh"
module decoder_asserts
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// lines and steps
	input wire logic pulse_in,
	input wire logic dir_in,
	input wire logic ref_step,
	input wire logic ref_fwd
);
	logic [8:0] quiet_r;
	logic [8:0] quiet_nxt;
	logic [1:0] prev_r;
	logic mapped;

	// quiet time since a line moved or a register was written
	always_comb
	begin
		mapped = paddr inside {`OFS_MODE, `OFS_FORM, `OFS_FILT, `OFS_POS, `OFS_STAT};
		quiet_nxt = (quiet_r == 9'h1FF) ? quiet_r : quiet_r + 9'h001;
		if ({pulse_in, dir_in} != prev_r || (pready && pwrite))
			quiet_nxt = 9'h000;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			quiet_r <= 9'h000;
			prev_r <= 2'h0;
		end
		else
		begin
			quiet_r <= quiet_nxt;
			prev_r <= {pulse_in, dir_in};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_access;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence

	a_ready_one_wait: assert property ($rose(penable) && psel |-> s_access)
		else $error("pready not one wait state after access start");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped address without pslverr");
	a_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("pslverr on a mapped address");
	a_unmapped_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_fwd_with_step: assert property ($changed(ref_fwd) |-> ref_step)
		else $error("direction changed without a step");
	a_step_timely: assert property (ref_step |-> quiet_r <= 9'h154)
		else $error("step long after any line change");
endmodule // decoder_asserts

bind pulse_train_reference_decoder decoder_asserts decoder_asserts_inst (.clk, .nrst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .pulse_in, .dir_in, .ref_step, .ref_fwd);

// ==== sim/host_pulse_model.sv ====
// host controller model driving the two reference lines
`timescale 1ns/1ns
module host_pulse_model
(
	// clock
	input wire logic clk,
	// inversion applied at the host side
	input wire logic [1:0] inv,
	// reference lines
	output logic line_a,
	output logic line_b
);
	initial
	begin
		line_a = 1'b0;
		line_b = 1'b0;
	end

	task automatic put(input logic a, input logic b, input int hold);
		@(posedge clk);
		line_a <= a ^ inv[1];
		line_b <= b ^ inv[0];
		repeat (hold) @(posedge clk);
	endtask

	// spacing keeps each form under its rate ceiling; slow suits the heavy filter
	task automatic emit(input logic [3:0] form, input logic fwd, input int n, input logic slow);
		int h;
		h = slow ? 400 : (form > 4'h1) ? 125 : 100;
		put(1'b0, (form == 4'h0) ? fwd : 1'b0, h);
		repeat (n)
		begin
			if (form == 4'h0)
			begin
				put(1'b1, fwd, h);
				put(1'b0, fwd, h);
			end
			else if (form == 4'h1)
			begin
				put(fwd, !fwd, h);
				put(1'b0, 1'b0, h);
			end
			else
			begin
				put(!fwd, fwd, h);
				put(1'b1, 1'b1, h);
				put(fwd, !fwd, h);
				put(1'b0, 1'b0, h);
			end
		end
	endtask
endmodule // host_pulse_model

// ==== sim/tb_pulse_train_reference_decoder.sv ====
// testbench of the pulse train reference decoder
`timescale 1ns/1ns
`include "pulse_ref_cfg.svh"
module tb_pulse_train_reference_decoder;
	import pulse_ref_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, pulse_in, dir_in, ref_step, ref_fwd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] inv_sel;
	pulse_form_t active_form;
	int error_cnt, total_checks, cyc, seed;

	pulse_train_reference_decoder pulse_train_reference_decoder_inst (.clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_in, .dir_in, .ref_step, .ref_fwd, .active_form);
	host_pulse_model host_pulse_model_inst (.clk, .inv(inv_sel), .line_a(pulse_in), .line_b(dir_in));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// whole run needs roughly 45k cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			$display("mismatch at %0t: timeout", $time);
			error_cnt++;
			report_and_stop();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			chk(32'h0, 32'h1);
	endtask

	function automatic logic [31:0] exp_delta(logic [3:0] f, logic fw, int n, logic en);
		int k;
		k = (f == 4'h3) ? 2 : (f == 4'h4) ? 4 : 1;
		if (!en || f > 4'h4)
			return 32'h0;
		return fw ? 32'(n * k) : 32'(-(n * k));
	endfunction

	// idle lines, take a baseline, send, let the filter settle, compare the count
	task automatic run(logic [3:0] f, logic [1:0] iv, logic fw, int n, logic slow, logic en);
		logic [31:0] p0;
		inv_sel <= iv;
		apb(1'b1, `OFS_FORM, {16'h0, 2'h0, iv, f, 8'h0});
		host_pulse_model_inst.put(1'b0, 1'b0, 400);
		if (f < 4'h5 && en)
			chk(32'(active_form), 32'(f));
		apb(1'b0, `OFS_POS, 32'h0);
		p0 = rd;
		host_pulse_model_inst.emit(f, fw, n, slow);
		repeat (400) @(posedge clk);
		apb(1'b0, `OFS_POS, 32'h0);
		chk(rd - p0, exp_delta(f, fw, n, en));
		if (exp_delta(f, fw, n, en) != 32'h0)
		begin
			chk(32'(ref_fwd), 32'(fw));
			apb(1'b0, `OFS_STAT, 32'h0);
			chk(rd, {26'h0, 1'b1, fw, (f == 4'h0) & fw, 1'b0, 2'h0});
		end
	endtask

	initial
	begin
		seed = 56;
		cyc = 0;
		error_cnt = 0;
		total_checks = 0;
		inv_sel = 2'h0;
		nrst = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(rd, `MODE_RST);
		apb(1'b0, `OFS_FORM, 32'h0);
		chk(rd, `FORM_RST);
		apb(1'b0, `OFS_FILT, 32'h0);
		chk(rd, `FILT_RST);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, `OFS_MODE, {24'h0, `MODE_POSITION, 4'h0});
		for (int f = 0; f < 6; f++)
			for (int d = 0; d < 2; d++)
				run(4'(f), 2'h0, 1'(d), 2, 1'b0, 1'b1);
		for (int i = 0; i < 4; i++)
			run(4'(i + 1), 2'(i), 1'(i), 1, 1'b0, 1'b1);
		repeat (6)
			run(4'({$random(seed)} % 5), 2'($random(seed)), 1'($random(seed)), 1 + {$random(seed)} % 3, 1'b0, 1'b1);
		apb(1'b1, `OFS_FILT, 32'h0000_1000);
		run(4'h1, 2'h0, 1'b1, 2, 1'b0, 1'b1);
		apb(1'b1, `OFS_FILT, 32'h0000_2000);
		run(4'h0, 2'h0, 1'b1, 2, 1'b0, 1'b0);
		run(4'h0, 2'h0, 1'b0, 2, 1'b1, 1'b1);
		apb(1'b1, `OFS_FILT, 32'h0);
		apb(1'b1, `OFS_MODE, 32'h0);
		run(4'h4, 2'h0, 1'b1, 1, 1'b0, 1'b0);
		apb(1'b1, `OFS_POS, 32'h0000_1234);
		apb(1'b0, `OFS_POS, 32'h0);
		chk(rd, 32'h0000_1234);
		report_and_stop();
	end
endmodule // tb_pulse_train_reference_decoder
